// file: sim/lin_position_command_decoder_asserts.sv
// Checker for the link wire and the node outcome pulses
`timescale 1ns/1ps
`default_nettype none
module lin_position_command_decoder_asserts
    import lin_pos_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    input  wire logic        byte_last,
    input  wire logic [15:0] TARGET_POSITION,
    input  wire logic        TARGET_STROBE,
    input  wire logic        FRAME_ERROR,
    input  wire logic        COMMAND_REFUSED
);
    // ----------
    // Helper state
    // ----------
    logic       in_frame_reg;
    logic [7:0] sum_reg;
    logic [8:0] add_next;
    logic       frame_start;
    assign frame_start = byte_valid && !in_frame_reg;
    assign add_next = {1'b0, sum_reg} + {1'b0, byte_data};
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N)
            in_frame_reg <= 1'b0;
        else if (byte_valid)
            in_frame_reg <= !byte_last;
    end
    // Identifier byte is left out of the sum
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N)
            sum_reg <= 8'h00;
        else if (frame_start)
            sum_reg <= 8'h00;
        else if (byte_valid && !byte_last)
            sum_reg <= add_next[7:0] + {7'h00, add_next[8]};
    end
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence frame_end;
        byte_valid && byte_last;
    endsequence
    sequence outcome;
        TARGET_STROBE || FRAME_ERROR || COMMAND_REFUSED;
    endsequence
    a_last_valid: assert property (byte_last |-> byte_valid)
        else $error("last flag without valid");
    a_bytes_back: assert property (byte_valid && !byte_last |=> byte_valid)
        else $error("gap inside frame");
    a_frame_idle: assert property (frame_end |=> !byte_valid)
        else $error("no idle after frame");
    a_id_parity: assert property (frame_start |-> byte_data[7:6] ==
        {~(byte_data[1] ^ byte_data[3] ^ byte_data[4] ^ byte_data[5]),
         byte_data[0] ^ byte_data[1] ^ byte_data[2] ^ byte_data[4]})
        else $error("identifier parity wrong");
    a_wire_csum: assert property (frame_end |-> byte_data == ~sum_reg)
        else $error("checksum byte wrong");
    a_outcome_cause: assert property (outcome |-> $past(byte_valid && byte_last))
        else $error("outcome pulse without frame end");
    a_target_hold: assert property (!TARGET_STROBE |-> $stable(TARGET_POSITION))
        else $error("target moved without strobe");
    a_one_outcome: assert property ($onehot0({TARGET_STROBE, FRAME_ERROR, COMMAND_REFUSED}))
        else $error("two outcome pulses at once");
    a_strobe_pulse: assert property (TARGET_STROBE |=> !TARGET_STROBE [*3])
        else $error("strobe too long");
endmodule
`default_nettype wire

// file: sim/lin_position_command_decoder_bench.sv
// Bench: master and node joined, plus a node fed by a faulty driver
`timescale 1ns/1ps
`default_nettype none
module lin_position_command_decoder_bench
    import lin_pos_pkg::*;
;
    // ----------
    // Wiring
    // ----------
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rdata;
    logic        rerr;
    logic [1:0]  step = 2'h0;
    logic        address_mode_select = 1'b0;
    logic        pin2 = 1'b1;
    logic        veto = 1'b0;
    logic [6:0]  otp = 7'h25;
    logic [4:0]  dtag = 5'h05;
    logic [3:0]  gtag = 4'h3;
    logic [4:0]  c1tag = 5'h09;
    logic [3:0]  c2tag = 4'h6;
    logic [15:0] tpos [2];
    logic [1:0]  stb;
    logic [1:0]  ferr;
    logic [1:0]  cref;
    int          errors = 0;
    int          checked = 0;
    lin_frame_if lnk [2] ();
    always #25 clk = ~clk;
    lin_position_master i_lin_position_master (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LINK(lnk[0]));
    for (genvar k = 0; k < 2; k++) begin : g_node
        // Address pins 0 and 1 strapped high for compact use
        lin_position_node i_lin_position_node (.CLK(clk), .RESET_N(rst_n), .LINK(lnk[k]),
            .STEP_RESOLUTION(step), .ADDRESS_MODE_SELECT(address_mode_select), .OTP_NODE_ADDRESS(otp),
            .HARDWARE_ADDRESS_PIN_0(1'b1), .HARDWARE_ADDRESS_PIN_1(1'b1), .HARDWARE_ADDRESS_PIN_2(pin2),
            .DIRECT_TAG(dtag), .GENERAL_TAG(gtag), .COMPACT_ONE_TAG(c1tag), .COMPACT_TWO_TAG(c2tag),
            .COMMAND_VETO(veto), .TARGET_POSITION(tpos[k]), .TARGET_STROBE(stb[k]),
            .FRAME_ERROR(ferr[k]), .COMMAND_REFUSED(cref[k]));
    end
    lin_position_command_decoder_asserts i_asserts (.CLK(clk), .RESET_N(rst_n),
        .byte_valid(lnk[0].byte_valid), .byte_data(lnk[0].byte_data), .byte_last(lnk[0].byte_last),
        .TARGET_POSITION(tpos[0]), .TARGET_STROBE(stb[0]), .FRAME_ERROR(ferr[0]),
        .COMMAND_REFUSED(cref[0]));
    // ----------
    // Tasks
    // ----------
    task chk(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(logic [7:0] a, logic w, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Byte 1 of the frame sits in d[7:0]
    task send(logic [5:0] id, logic [3:0] n, logic [63:0] d);
        apb(REG_ID, 1'b1, {26'h0, id});
        apb(REG_LEN, 1'b1, {28'h0, n});
        apb(REG_DATA_LO, 1'b1, d[31:0]);
        apb(REG_DATA_HI, 1'b1, d[63:32]);
        apb(REG_CTRL, 1'b1, 32'h1);
    endtask
    // Faulty sender: fi and fc flip identifier and checksum bits
    task raw(logic [5:0] id, logic [63:0] d, int n, logic [7:0] fi, logic [7:0] fc);
        logic [7:0] s;
        logic [8:0] t;
        s = 8'h00;
        @(posedge clk);
        lnk[1].byte_valid <= 1'b1;
        lnk[1].byte_data <= {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id} ^ fi;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            lnk[1].byte_data <= d[8*i+:8];
            t = {1'b0, s} + {1'b0, d[8*i+:8]};
            s = t[7:0] + {7'h00, t[8]};
        end
        @(posedge clk);
        lnk[1].byte_data <= ~s ^ fc;
        lnk[1].byte_last <= 1'b1;
        @(posedge clk);
        lnk[1].byte_valid <= 1'b0;
        lnk[1].byte_last <= 1'b0;
        lnk[1].byte_data <= s ^ fc;
    endtask
    // Outcome bits: strobe, error, refused
    task watch(int k, logic [2:0] exp, logic [15:0] pos);
        logic [2:0] seen;
        seen = 3'b000;
        repeat (40) begin
            @(posedge clk);
            seen = seen | {stb[k], ferr[k], cref[k]};
        end
        chk("outcome", {29'h0, exp}, {29'h0, seen});
        chk("target", {16'h0, pos}, {16'h0, tpos[k]});
    endtask
    // ----------
    // Scenarios
    // ----------
    task t_direct;
        send(6'h05, 4'h2, 64'h2381);
        watch(0, 3'b100, 16'h8123);
        send(6'h07, 4'h2, 64'h5566);
        watch(0, 3'b000, 16'h8123);
    endtask
    task t_general;
        send(6'h23, 4'h4, 64'h3412918b);
        watch(0, 3'b000, 16'h8123);
        send(6'h23, 4'h4, 64'h5634118b);
        watch(0, 3'b100, 16'h3456);
        send(6'h23, 4'h4, 64'h7856a58b);
        watch(0, 3'b100, 16'h5678);
        send(6'h23, 4'h4, 64'h9a78a58c);
        watch(0, 3'b000, 16'h5678);
    endtask
    task t_dual;
        send(MASTER_REQ_ID, 4'h8, 64'hdcfea52211918b80);
        watch(0, 3'b100, 16'hfedc);
        send(MASTER_REQ_ID, 4'h8, 64'h0102a50304918b81);
        watch(0, 3'b000, 16'hfedc);
    endtask
    task t_compact;
        send(6'h09, 4'h2, 64'h3cb5);
        watch(0, 3'b100, 16'hfd3c);
        for (int m = 1; m < 4; m++) begin
            step <= m[1:0];
            send(6'h09, 4'h2, 64'h3db5);
            watch(0, 3'b000, 16'hfd3c);
        end
        step <= 2'h0;
        address_mode_select <= 1'b1;
        send(6'h09, 4'h2, 64'h115d);
        watch(0, 3'b100, 16'h0211);
        pin2 <= 1'b0;
        send(6'h09, 4'h2, 64'h125d);
        watch(0, 3'b000, 16'h0211);
        send(6'h09, 4'h2, 64'h0061);
        watch(0, 3'b100, 16'h0300);
        address_mode_select <= 1'b0;
        pin2 <= 1'b1;
        send(6'h26, 4'h4, 64'h993544f3);
        watch(0, 3'b100, 16'h0199);
    endtask
    task t_veto;
        veto <= 1'b1;
        send(6'h05, 4'h2, 64'h5544);
        watch(0, 3'b001, 16'h0199);
        veto <= 1'b0;
    endtask
    task t_faults;
        raw(6'h05, 64'h0201, 2, 8'h00, 8'h00);
        watch(1, 3'b100, 16'h0102);
        raw(6'h05, 64'h0403, 2, 8'h80, 8'h00);
        watch(1, 3'b010, 16'h0102);
        raw(6'h05, 64'h0403, 2, 8'h00, 8'h01);
        watch(1, 3'b010, 16'h0102);
    endtask
    // Seventeen frames have gone out through the master by now
    task t_regs;
        apb(8'h18, 1'b0, 32'h0);
        chk("slverr", 32'h1, {31'h0, rerr});
        chk("unmapped", 32'h0, rdata);
        apb(REG_ID, 1'b0, 32'h0);
        chk("id", 32'h5, rdata);
        apb(REG_LEN, 1'b0, 32'h0);
        chk("len", 32'h2, rdata);
        apb(REG_DATA_LO, 1'b0, 32'h0);
        chk("data_lo", 32'h5544, rdata);
        apb(REG_STATUS, 1'b0, 32'h0);
        chk("status", 32'h22, {23'h0, rdata[15:8], rdata[0]});
    endtask
    task give_verdict;
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------
    // Run
    // ----------
    initial begin
        lnk[1].byte_valid = 1'b0;
        lnk[1].byte_data = 8'h00;
        lnk[1].byte_last = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_direct();
        t_general();
        t_dual();
        t_compact();
        t_veto();
        t_faults();
        t_regs();
        give_verdict();
    end
    // Whole run needs about 1200 cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire

// file: src/lin_csum_acc.sv
// Running checksum over the data bytes of one frame
`timescale 1ns/1ps
`default_nettype none
module lin_csum_acc
    import lin_pos_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clear,
    input  wire logic       add,
    input  wire logic [7:0] data,
    output logic      [7:0] sum_reg
);
    // Clear wins: a frame boundary never carries a data byte
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sum_reg <= 8'h00;
        end else if (clear) begin
            sum_reg <= 8'h00;
        end else if (add) begin
            sum_reg <= csum_add(sum_reg, data);
        end
    end
endmodule
`default_nettype wire

// file: src/lin_frame_if.sv
// Byte-level frame link between the bus master and the motor node
`timescale 1ns/1ps
`default_nettype none
interface lin_frame_if;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       byte_last;

    modport master (
        output byte_valid,
        output byte_data,
        output byte_last
    );
    modport node (
        input  byte_valid,
        input  byte_data,
        input  byte_last
    );
endinterface
`default_nettype wire

// file: src/lin_pos_pkg.sv
// Shared constants, field layouts and frame helpers for the position link
package lin_pos_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int          BYTE_W        = 8;
    localparam logic [3:0]  LEN_SHORT     = 4'h2;
    localparam logic [3:0]  LEN_GP        = 4'h4;
    localparam logic [3:0]  LEN_MASTER    = 4'h8;
    localparam logic [3:0]  MAX_DATA      = 4'h8;
    localparam logic [5:0]  MASTER_REQ_ID = 6'h3c;
    localparam logic [7:0]  APP_CODE      = 8'h80;
    localparam logic [6:0]  CMD_GOTO      = 7'h0b;
    localparam logic [1:0]  STEP_HALF     = 2'h0;
    localparam logic [1:0]  ID_GP_PREFIX  = 2'h2;
    localparam int          FLAG_BIT      = 7;
    localparam int          ID_WIDE_BIT   = 5;
    localparam int          CBROAD_BIT    = 4;

    // ------------------------------------------------------------
    // Controller register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_ID        = 8'h04;
    localparam logic [7:0]  REG_LEN       = 8'h08;
    localparam logic [7:0]  REG_DATA_LO   = 8'h0c;
    localparam logic [7:0]  REG_DATA_HI   = 8'h10;
    localparam logic [7:0]  REG_STATUS    = 8'h14;
    localparam int          CTRL_GO_BIT   = 0;

    // Identifier with its two parity bits on top
    function automatic logic [7:0] lin_protect(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction

    // Sum with end-around carry
    function automatic logic [7:0] csum_add(input logic [7:0] s, input logic [7:0] d);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, d};
        return t[7:0] + {7'h00, t[8]};
    endfunction

    // Compact entry: three high bits in the top of the first byte
    function automatic logic [15:0] compact_pos(input logic [7:0] hi, input logic [7:0] lo);
        return {{5{hi[7]}}, hi[7:5], lo};
    endfunction

endpackage

// file: src/lin_position_master.sv
// Bus master end: APB-programmed frame sender
`timescale 1ns/1ps
`default_nettype none
module lin_position_master
    import lin_pos_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    lin_frame_if.master            LINK
);
    typedef enum logic [1:0] {IDLE, SEND_DATA, SEND_SUM} send_t;

    send_t       state_reg;
    logic [5:0]  id_reg;
    logic [3:0]  len_reg;
    logic [31:0] lo_reg;
    logic [31:0] hi_reg;
    logic [3:0]  idx_reg;
    logic [7:0]  sent_reg;
    logic [7:0]  sum;
    logic [7:0]  data_next;
    logic        wr_fire;
    logic        go;
    logic        mapped;
    logic [7:0]  addr;
    logic        busy;

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    assign addr    = PADDR[7:0];
    assign wr_fire = PSEL && PENABLE && PWRITE && PREADY;
    // Checksum cycle counts as busy, so frames always keep an idle gap
    assign busy    = state_reg != IDLE || LINK.byte_last;
    assign go      = wr_fire && addr == REG_CTRL && PWDATA[CTRL_GO_BIT] && !busy;
    assign mapped  = addr == REG_CTRL || addr == REG_ID || addr == REG_LEN
                  || addr == REG_DATA_LO || addr == REG_DATA_HI || addr == REG_STATUS;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
            PRDATA  <= 32'h0000_0000;
            if (PSEL && PENABLE && !PREADY && !PWRITE) begin
                unique case (addr)
                    REG_ID:      PRDATA <= {26'h0, id_reg};
                    REG_LEN:     PRDATA <= {28'h0, len_reg};
                    REG_DATA_LO: PRDATA <= lo_reg;
                    REG_DATA_HI: PRDATA <= hi_reg;
                    REG_STATUS:  PRDATA <= {16'h0, sent_reg, 7'h00, busy};
                    default:     PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Frame contents are frozen while a frame is on the link
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            id_reg  <= 6'h00;
            len_reg <= 4'h0;
            lo_reg  <= 32'h0000_0000;
            hi_reg  <= 32'h0000_0000;
        end else if (wr_fire && !busy) begin
            if (addr == REG_ID) id_reg <= PWDATA[5:0];
            if (addr == REG_LEN) len_reg <= PWDATA[3:0];
            if (addr == REG_DATA_LO) lo_reg <= PWDATA;
            if (addr == REG_DATA_HI) hi_reg <= PWDATA;
        end
    end

    // ------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------
    always_comb begin
        logic [63:0] all;
        all       = {hi_reg, lo_reg};
        data_next = all[{idx_reg[2:0] - 3'h1, 3'h0} +: 8];
    end

    lin_csum_acc u_csum (
        .clk     (CLK),
        .reset_n (RESET_N),
        .clear   (go),
        .add     (state_reg == SEND_DATA),
        .data    (data_next),
        .sum_reg (sum)
    );

    // Parity is always generated here; software only gives the tag
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg       <= IDLE;
            idx_reg         <= 4'h0;
            sent_reg        <= 8'h00;
            LINK.byte_valid <= 1'b0;
            LINK.byte_data  <= 8'h00;
            LINK.byte_last  <= 1'b0;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    LINK.byte_valid <= go;
                    LINK.byte_last  <= 1'b0;
                    if (go) begin
                        LINK.byte_data <= lin_protect(id_reg);
                        idx_reg        <= 4'h1;
                        state_reg      <= (len_reg == 4'h0) ? SEND_SUM : SEND_DATA;
                    end
                end
                SEND_DATA: begin
                    LINK.byte_data <= data_next;
                    idx_reg        <= idx_reg + 4'h1;
                    if (idx_reg == len_reg) state_reg <= SEND_SUM;
                end
                SEND_SUM: begin
                    LINK.byte_data <= ~sum;
                    LINK.byte_last <= 1'b1;
                    sent_reg       <= sent_reg + 8'h01;
                    state_reg      <= IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: src/lin_position_node.sv
// Motor node end: decodes absolute-position frames into a target
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module lin_position_node
    import lin_pos_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    lin_frame_if.node        LINK,
    input  wire logic [1:0]  STEP_RESOLUTION,
    input  wire logic        ADDRESS_MODE_SELECT,
    input  wire logic [6:0]  OTP_NODE_ADDRESS,
    input  wire logic        HARDWARE_ADDRESS_PIN_0,
    input  wire logic        HARDWARE_ADDRESS_PIN_1,
    input  wire logic        HARDWARE_ADDRESS_PIN_2,
    input  wire logic [4:0]  DIRECT_TAG,
    input  wire logic [3:0]  GENERAL_TAG,
    input  wire logic [4:0]  COMPACT_ONE_TAG,
    input  wire logic [3:0]  COMPACT_TWO_TAG,
    input  wire logic        COMMAND_VETO,
    output logic      [15:0] TARGET_POSITION,
    output logic             TARGET_STROBE,
    output logic             FRAME_ERROR,
    output logic             COMMAND_REFUSED
);

    // ------------------------------------------------------------
    // Byte capture
    // ------------------------------------------------------------
    logic [7:0]  frame_mem [0:8];
    logic [3:0]  cnt_reg;
    logic [3:0]  n_data;
    logic [7:0]  sum;
    logic        data_byte;
    logic        frame_end;

    assign frame_end = LINK.byte_valid && LINK.byte_last;
    assign data_byte = LINK.byte_valid && !LINK.byte_last && cnt_reg != 4'h0;
    assign n_data    = cnt_reg - 4'h1;

    // Count saturates past the longest frame so an overlong frame
    // still ends cleanly and is thrown away on its length
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_reg <= 4'h0;
        end else if (frame_end) begin
            cnt_reg <= 4'h0;
        end else if (LINK.byte_valid && cnt_reg <= MAX_DATA + 4'h1) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (LINK.byte_valid && !LINK.byte_last && cnt_reg <= MAX_DATA) begin
            frame_mem[cnt_reg] <= LINK.byte_data;
        end
    end

    lin_csum_acc u_csum (
        .clk     (CLK),
        .reset_n (RESET_N),
        .clear   (frame_end),
        .add     (data_byte),
        .data    (LINK.byte_data),
        .sum_reg (sum)
    );

    // ------------------------------------------------------------
    // Addresses
    // ------------------------------------------------------------
    logic [3:0]  own_short;
    logic        half_step;

    // Bit 3 comes from pin 2 only in address mode 1
    // Pins 0 and 1 are assumed strapped high by the board
    assign own_short = {ADDRESS_MODE_SELECT ? HARDWARE_ADDRESS_PIN_2 : OTP_NODE_ADDRESS[3],
                        OTP_NODE_ADDRESS[2:0]};
    assign half_step = STEP_RESOLUTION == STEP_HALF;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [7:0]  id_byte;
    logic [5:0]  tag;
    logic        frame_ok;
    logic        hit;
    logic [15:0] pos;
    logic [7:0]  goto_cmd;

    assign id_byte  = frame_mem[0];
    assign tag      = id_byte[5:0];
    assign goto_cmd = {1'b1, CMD_GOTO};
    // Wrong parity, wrong checksum or no identifier drops the frame
    assign frame_ok = cnt_reg != 4'h0 && cnt_reg <= MAX_DATA + 4'h1
                   && id_byte == lin_protect(tag)
                   && LINK.byte_data == ~sum;

    always_comb begin
        hit = 1'b0;
        pos = 16'h0000;
        // Direct or general tag wins if software gave a compact kind the same tag
        if (n_data == LEN_SHORT && !tag[ID_WIDE_BIT]) begin
            if (tag[4:0] == DIRECT_TAG) begin
                hit = 1'b1;
                pos = {frame_mem[1], frame_mem[2]};
            end else if (tag[4:0] == COMPACT_ONE_TAG && half_step) begin
                hit = !frame_mem[1][CBROAD_BIT]
                   || frame_mem[1][3:0] == own_short;
                pos = compact_pos(frame_mem[1], frame_mem[2]);
            end
        end else if (n_data == LEN_GP && tag[5:4] == ID_GP_PREFIX) begin
            if (tag[3:0] == GENERAL_TAG) begin
                hit = frame_mem[1] == goto_cmd
                   && (!frame_mem[2][FLAG_BIT]
                   || frame_mem[2][6:0] == OTP_NODE_ADDRESS);
                pos = {frame_mem[3], frame_mem[4]};
            end else if (tag[3:0] == COMPACT_TWO_TAG && half_step) begin
                if (frame_mem[1][CBROAD_BIT] && frame_mem[1][3:0] == own_short) begin
                    hit = 1'b1;
                    pos = compact_pos(frame_mem[1], frame_mem[2]);
                end else if (frame_mem[3][CBROAD_BIT] && frame_mem[3][3:0] == own_short) begin
                    hit = 1'b1;
                    pos = compact_pos(frame_mem[3], frame_mem[4]);
                end
            end
        end else if (n_data == LEN_MASTER && tag == MASTER_REQ_ID
                     && frame_mem[1] == APP_CODE && frame_mem[2] == goto_cmd) begin
            if (frame_mem[3] == {1'b1, OTP_NODE_ADDRESS}) begin
                hit = 1'b1;
                pos = {frame_mem[4], frame_mem[5]};
            end else if (frame_mem[6] == {1'b1, OTP_NODE_ADDRESS}) begin
                hit = 1'b1;
                pos = {frame_mem[7], frame_mem[8]};
            end
        end
    end

    // ------------------------------------------------------------
    // Target update
    // ------------------------------------------------------------
    // Veto is sampled in the checksum cycle; a veto raised later
    // cannot recall a target already handed over
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            TARGET_POSITION <= 16'h0000;
            TARGET_STROBE   <= 1'b0;
            FRAME_ERROR     <= 1'b0;
            COMMAND_REFUSED <= 1'b0;
        end else begin
            TARGET_STROBE   <= 1'b0;
            FRAME_ERROR     <= frame_end && !frame_ok;
            COMMAND_REFUSED <= frame_end && frame_ok && hit && COMMAND_VETO;
            if (frame_end && frame_ok && hit && !COMMAND_VETO) begin
                TARGET_POSITION <= pos;
                TARGET_STROBE   <= 1'b1;
            end
        end
    end

    // Pins 0 and 1 only matter to the long physical address, which
    // the node address input already carries whole
    logic unused_pins;
    assign unused_pins = HARDWARE_ADDRESS_PIN_0 & HARDWARE_ADDRESS_PIN_1;

endmodule
`default_nettype wire
